/* rtl/ecd_top.sv */
// Purpose: contact flags, alarm relays, clutch relay and indicators
// Assumes: pin high means contact closed; alarm causes, settings,
//          speed and network status come from logic on i_clk
// Notes: long times are parameters so a simulation can shorten them
`timescale 1ns/1ps
`include "ecd_params.svh"

module ecd_top #(
  parameter int NW = 4,
  parameter int NS = 4,
  parameter int DEB_CYC = `ECD_DEB_CYC,
  parameter int BOOT_CYC = `ECD_BOOT_CYC,
  parameter int FLASH_CYC = `ECD_FLASH_CYC
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire ecd_pkg::ecd_contact_t i_contact,
  input wire logic i_port_sel_contact,
  input wire logic i_is_slave,
  input wire logic [NW-1:0] i_warning_cause,
  input wire logic [NS-1:0] i_severe_cause,
  input wire logic i_warning_relay_polarity,
  input wire logic i_severe_relay_polarity,
  input wire logic i_input_f_role_select,
  input wire logic i_permissives_ok,
  input wire logic i_load_at_unload_trip,
  input wire logic i_run_mode,
  input wire logic [1:0] i_below_failsafe,
  input wire ecd_pkg::ecd_node_t i_net_node_id_chan_one,
  input wire ecd_pkg::ecd_node_t i_net_node_id_chan_two,
  input wire logic [1:0] i_chan_fault,
  input wire logic i_reset_all_alarms,
  output logic [`ECD_N_CONTACT-1:0] o_contact_status,
  output logic o_external_setpoint_chosen,
  output logic o_pc_link_chosen,
  output logic o_handheld_enable,
  output logic o_warning_alarm,
  output logic o_severe_alarm,
  output logic o_relay_one,
  output logic o_relay_two,
  output logic o_clutch_relay,
  output logic o_unload_request,
  output logic o_torque_limit_active,
  output logic o_emergency_declutch,
  output logic [1:0] o_sensor_fail_led,
  output logic o_led_three,
  output logic o_led_four,
  output logic o_net_functions_enable,
  output logic o_cpu_led
);
  import ecd_pkg::*;

  localparam int BW = $clog2(BOOT_CYC + 1);
  localparam int FW = $clog2(FLASH_CYC + 1);

  // ----------------------------------------
  // Contact conditioning
  // ----------------------------------------
  ecd_if #(.N(`ECD_N_IN)) u_if ();

  // Selector pin rides above the eight contacts
  assign u_if.raw = {i_port_sel_contact, i_contact};

  ecd_debounce #(
    .N(`ECD_N_IN),
    .DEB_CYC(DEB_CYC)
  ) u_deb (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .bus(u_if.deb)
  );

  // Named views of the cleaned contacts
  wire [`ECD_N_IN-1:0] cl = u_if.clean;
  wire raise_c = cl[`ECD_IN_RAISE];
  wire lower_c = cl[`ECD_IN_LOWER];
  wire arst_c = cl[`ECD_IN_ARST];
  wire f_c = cl[`ECD_IN_F];
  wire demand_c = cl[`ECD_IN_DEMAND];
  wire engaged_c = cl[`ECD_IN_ENGAGED];
  wire sel_c = cl[`ECD_IN_SEL];

  // ----------------------------------------
  // Contact flags and port selection
  // ----------------------------------------
  wire ext_sp_d = raise_c && lower_c && !i_is_slave;

  // Flags follow the debounced level, one flop late
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_contact_status <= '0;
      o_external_setpoint_chosen <= `ECD_RST_BIT;
      o_pc_link_chosen <= `ECD_RST_BIT;
      o_handheld_enable <= 1'b1;
    end else begin
      o_contact_status <= cl[`ECD_N_CONTACT-1:0];
      o_external_setpoint_chosen <= ext_sp_d;
      o_pc_link_chosen <= sel_c;
      o_handheld_enable <= !sel_c;
    end
  end

  // ----------------------------------------
  // Alarm latches and reset
  // ----------------------------------------
  logic sw_rst_prev_q;
  logic arst_prev_q;
  logic [NW-1:0] warn_lat_q;
  logic [NS-1:0] sev_lat_q;
  logic [1:0] sfail_q;

  // Either the setting or the reset contact rising clears
  wire clr = (i_reset_all_alarms && !sw_rst_prev_q) || (arst_c && !arst_prev_q);

  // A live cause always wins over a clear
  wire [NW-1:0] warn_lat_d = (warn_lat_q & ~({NW{clr}} & ~i_warning_cause))
                           | i_warning_cause;
  wire [NS-1:0] sev_lat_d = (sev_lat_q & ~({NS{clr}} & ~i_severe_cause))
                          | i_severe_cause;
  wire [1:0] sfail_cause = i_below_failsafe & {2{i_run_mode}};
  wire [1:0] sfail_d = (sfail_q & ~({2{clr}} & ~sfail_cause)) | sfail_cause;

  wire warn_d = |warn_lat_d;
  wire sev_d = |sev_lat_d;

  // Latches and edge history
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      sw_rst_prev_q <= `ECD_RST_BIT;
      arst_prev_q <= `ECD_RST_BIT;
      warn_lat_q <= '0;
      sev_lat_q <= '0;
      sfail_q <= '0;
    end else begin
      sw_rst_prev_q <= i_reset_all_alarms;
      arst_prev_q <= arst_c;
      warn_lat_q <= warn_lat_d;
      sev_lat_q <= sev_lat_d;
      sfail_q <= sfail_d;
    end
  end

  // Alarm flags, relays and sensor lamps
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_warning_alarm <= `ECD_RST_BIT;
      o_severe_alarm <= `ECD_RST_BIT;
      o_relay_one <= `ECD_RST_BIT;
      o_relay_two <= `ECD_RST_BIT;
      o_sensor_fail_led <= '0;
    end else begin
      o_warning_alarm <= warn_d;
      o_severe_alarm <= sev_d;
      o_relay_one <= warn_d ^ i_warning_relay_polarity;
      o_relay_two <= sev_d ^ i_severe_relay_polarity;
      o_sensor_fail_led <= sfail_d;
    end
  end

  // ----------------------------------------
  // Clutch command
  // ----------------------------------------
  ecd_clutch_e cl_st_q;
  ecd_clutch_e cl_st_d;

  wire emerg = !i_input_f_role_select && f_c;
  wire torque_d = i_input_f_role_select && f_c;
  wire engage_ok = engaged_c || (demand_c && i_permissives_ok);

  // Emergency beats everything; unload holds relay until trip point
  always_comb begin
    cl_st_d = cl_st_q;
    case (cl_st_q)
      ECD_CL_OPEN: begin
        if (!emerg && engage_ok) begin
          cl_st_d = ECD_CL_CLOSED;
        end
      end
      ECD_CL_CLOSED: begin
        if (emerg) begin
          cl_st_d = ECD_CL_OPEN;
        end else if (!demand_c) begin
          cl_st_d = i_load_at_unload_trip ? ECD_CL_OPEN : ECD_CL_UNLOAD;
        end
      end
      ECD_CL_UNLOAD: begin
        if (emerg) begin
          cl_st_d = ECD_CL_OPEN;
        end else if (demand_c) begin
          cl_st_d = ECD_CL_CLOSED;
        end else if (i_load_at_unload_trip) begin
          cl_st_d = ECD_CL_OPEN;
        end
      end
      default: begin
        cl_st_d = ECD_CL_OPEN;
      end
    endcase
  end

  // Relay drives from the next state so it moves with the state
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      cl_st_q <= ECD_CL_OPEN;
      o_clutch_relay <= `ECD_RST_BIT;
      o_unload_request <= `ECD_RST_BIT;
      o_torque_limit_active <= `ECD_RST_BIT;
      o_emergency_declutch <= `ECD_RST_BIT;
    end else begin
      cl_st_q <= cl_st_d;
      o_clutch_relay <= cl_st_d != ECD_CL_OPEN;
      o_unload_request <= cl_st_d == ECD_CL_UNLOAD;
      o_torque_limit_active <= torque_d;
      o_emergency_declutch <= emerg;
    end
  end

  // ----------------------------------------
  // Network indicators
  // ----------------------------------------
  logic [FW-1:0] fl_cnt_q;
  logic fl_ph_q;

  // Zero reads as unset, all ones or a duplicate as improper
  wire id1_bad = i_net_node_id_chan_one == `ECD_NODE_UNSET
              || i_net_node_id_chan_one == `ECD_NODE_BAD;
  wire id2_bad = i_net_node_id_chan_two == `ECD_NODE_UNSET
              || i_net_node_id_chan_two == `ECD_NODE_BAD;
  wire id_bad = id1_bad || id2_bad
             || i_net_node_id_chan_one == i_net_node_id_chan_two;
  wire fl_wrap = fl_cnt_q == FW'(FLASH_CYC - 1);
  wire both_flt = &i_chan_fault;

  // Free-running flash phase
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      fl_cnt_q <= '0;
      fl_ph_q <= `ECD_RST_BIT;
    end else begin
      fl_cnt_q <= fl_wrap ? '0 : fl_cnt_q + 1'b1;
      fl_ph_q <= fl_ph_q ^ fl_wrap;
    end
  end

  // Lamps and the network function enable
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      o_led_three <= `ECD_RST_BIT;
      o_led_four <= `ECD_RST_BIT;
      o_net_functions_enable <= `ECD_RST_BIT;
    end else begin
      o_led_three <= id_bad && fl_ph_q;
      o_led_four <= both_flt;
      o_net_functions_enable <= !both_flt;
    end
  end

  // ----------------------------------------
  // Start-up indicator
  // ----------------------------------------
  logic [BW-1:0] boot_cnt_q;
  wire boot_done = boot_cnt_q == BW'(BOOT_CYC - 1);

  // Counts once after reset, then holds the lamp on
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      boot_cnt_q <= '0;
      o_cpu_led <= `ECD_RST_BIT;
    end else begin
      if (!boot_done) begin
        boot_cnt_q <= boot_cnt_q + 1'b1;
      end
      o_cpu_led <= o_cpu_led || boot_done;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  property p_ext_sp;
    $past(i_rstn) |-> o_external_setpoint_chosen == $past(raise_c && lower_c && !i_is_slave);
  endproperty
  a_ext_sp: assert property (p_ext_sp) else $error("setpoint flag wrong");

  property p_port_sel;
    $past(i_rstn) |-> (o_pc_link_chosen != o_handheld_enable)
                      && (o_pc_link_chosen == $past(sel_c));
  endproperty
  a_port_sel: assert property (p_port_sel) else $error("port select wrong");

  property p_relay_one;
    $past(i_rstn) |-> o_relay_one == (o_warning_alarm ^ $past(i_warning_relay_polarity));
  endproperty
  a_relay_one: assert property (p_relay_one) else $error("relay one wrong");

  property p_relay_two;
    $past(i_rstn) |-> o_relay_two == (o_severe_alarm ^ $past(i_severe_relay_polarity));
  endproperty
  a_relay_two: assert property (p_relay_two) else $error("relay two wrong");

  property p_warn_set;
    (|i_warning_cause) |=> o_warning_alarm;
  endproperty
  a_warn_set: assert property (p_warn_set) else $error("warning missed");

  property p_sev_clear;
    $rose(i_reset_all_alarms) && !(|i_severe_cause) |=> !o_severe_alarm;
  endproperty
  a_sev_clear: assert property (p_sev_clear) else $error("severe not cleared");

  property p_engage;
    !emerg && demand_c && engage_ok |=> o_clutch_relay;
  endproperty
  a_engage: assert property (p_engage) else $error("clutch not closed");

  property p_unload_hold;
    o_clutch_relay && !demand_c && !i_load_at_unload_trip && !emerg |=> o_clutch_relay;
  endproperty
  a_unload_hold: assert property (p_unload_hold) else $error("early declutch");

  property p_emerg;
    emerg |=> !o_clutch_relay ##0 o_emergency_declutch;
  endproperty
  a_emerg: assert property (p_emerg) else $error("emergency ignored");

  property p_sfail;
    i_run_mode && i_below_failsafe[0] |=> o_sensor_fail_led[0];
  endproperty
  a_sfail: assert property (p_sfail) else $error("sensor lamp off");

  property p_net_off;
    o_led_four |-> !o_net_functions_enable && $past(both_flt);
  endproperty
  a_net_off: assert property (p_net_off) else $error("network not held");

  property p_cpu;
    $rose(o_cpu_led) |-> $past(boot_done);
  endproperty
  a_cpu: assert property (p_cpu) else $error("cpu lamp early");

  c_emerg: cover property (o_clutch_relay ##1 !o_clutch_relay && o_emergency_declutch);
  c_unload: cover property (o_unload_request ##1 !o_clutch_relay);
  c_both_flt: cover property ($rose(o_led_four));
  c_cpu: cover property ($rose(o_cpu_led));
endmodule

/* shared/ecd_params.svh */
// Purpose: constants of the engine discrete I/O block
// Assumes: 40 MHz system clock
// Notes: times kept in their own unit, cycle counts derived
`ifndef ECD_PARAMS_SVH
`define ECD_PARAMS_SVH
// ----------------------------------------
// Timing
// ----------------------------------------
`define ECD_CLK_HZ 40000000
`define ECD_DEB_MS 10
`define ECD_DEB_CYC (`ECD_DEB_MS * (`ECD_CLK_HZ / 1000))
`define ECD_BOOT_S 20
`define ECD_BOOT_CYC (`ECD_BOOT_S * `ECD_CLK_HZ)
`define ECD_FLASH_MS 250
`define ECD_FLASH_CYC (`ECD_FLASH_MS * (`ECD_CLK_HZ / 1000))
// ----------------------------------------
// Contact positions
// ----------------------------------------
`define ECD_IN_RUN 0
`define ECD_IN_MANV 1
`define ECD_IN_RAISE 2
`define ECD_IN_LOWER 3
`define ECD_IN_ARST 4
`define ECD_IN_F 5
`define ECD_IN_DEMAND 6
`define ECD_IN_ENGAGED 7
`define ECD_IN_SEL 8
`define ECD_N_CONTACT 8
`define ECD_N_IN 9
// ----------------------------------------
// Node id checks and reset values
// ----------------------------------------
`define ECD_NODE_W 8
`define ECD_NODE_UNSET 8'h00
`define ECD_NODE_BAD 8'hFF
`define ECD_RST_BIT 1'b0
`endif

/* shared/ecd_pkg.sv */
// Purpose: types of the engine discrete I/O block
// Assumes: constants come from the params header
// Notes: none
`include "ecd_params.svh"
package ecd_pkg;
  typedef logic [`ECD_N_CONTACT-1:0] ecd_contact_t;
  typedef logic [`ECD_NODE_W-1:0] ecd_node_t;
  typedef enum logic [1:0] {
    ECD_CL_OPEN,
    ECD_CL_CLOSED,
    ECD_CL_UNLOAD
  } ecd_clutch_e;
endpackage

/* shared/ecd_if.sv */
// Purpose: raw and cleaned contact levels between top and debouncer
// Assumes: one clock
// Notes: none
`timescale 1ns/1ps
interface ecd_if #(
  parameter int N = 9
);
  logic [N-1:0] raw;
  logic [N-1:0] clean;
  modport src (output raw, input clean);
  modport deb (input raw, output clean);
endinterface

/* rtl/ecd_debounce.sv */
// Purpose: two-stage synchroniser and debounce per contact
// Assumes: contact pins are asynchronous to i_clk
// Notes: a level must hold DEB_CYC cycles before it is taken
`timescale 1ns/1ps
module ecd_debounce #(
  parameter int N = 9,
  parameter int DEB_CYC = 400000
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  ecd_if.deb bus
);
  localparam int CW = $clog2(DEB_CYC + 1);

  // ----------------------------------------
  // Per contact channel
  // ----------------------------------------
  for (genvar g = 0; g < N; g++) begin : g_ch
    logic s1_q;
    logic s2_q;
    logic cl_q;
    logic [CW-1:0] cnt_q;
    wire diff = s2_q != cl_q;
    wire done = cnt_q == CW'(DEB_CYC - 1);

    // First stage read only by second stage
    always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
        s1_q <= `ECD_RST_BIT;
        s2_q <= `ECD_RST_BIT;
      end else begin
        s1_q <= bus.raw[g];
        s2_q <= s1_q;
      end
    end

    // Restart count whenever level bounces back
    always_ff @(posedge i_clk) begin
      if (!i_rstn) begin
        cnt_q <= '0;
        cl_q <= `ECD_RST_BIT;
      end else begin
        cnt_q <= (diff && !done) ? cnt_q + 1'b1 : '0;
        if (diff && done) begin
          cl_q <= s2_q;
        end
      end
    end

    assign bus.clean[g] = cl_q;
  end
endmodule

/* bench/ecd_field.sv */
// Purpose: field switches wired to the contact pins of the block
// Assumes: a thrown switch chatters for one cycle before it settles
// Notes: chatter is far shorter than the debounce time
`timescale 1ns/1ps
module ecd_field (
  input wire logic i_clk,
  input wire logic [8:0] i_close,
  output logic [8:0] o_pin
);
  logic [8:0] last_q = '0;
  logic [8:0] chat_q = '0;
  // Remember last position and flag bits that just moved
  always_ff @(posedge i_clk) begin
    last_q <= i_close;
    chat_q <= last_q ^ i_close;
  end
  // Pin reads new, old, new: a bounce that must not leak into flags
  assign o_pin = i_close ^ chat_q;
endmodule

/* bench/ecd_top_test.sv */
// Purpose: self-checking bench for the engine discrete I/O block
// Assumes: short debounce, boot and flash counts
// Notes: a driver queues expected values, a watcher compares them
`timescale 1ns/1ps
module ecd_top_test;
  import ecd_pkg::*;
  localparam int DEB = 4;
  localparam int BOOT = 50;
  localparam int FLASH = 8;
  localparam int SETTLE = 14; // sync, chatter, debounce, output flop
  typedef struct {string nm; int sel; logic [7:0] exp;} ecd_note_s;
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic [8:0] close = '0;
  logic [8:0] pin;
  logic slave = 1'b0, pol_w = 1'b0, pol_s = 1'b0, role = 1'b0, perm = 1'b0;
  logic trip = 1'b0, run = 1'b0, rst_all = 1'b0;
  logic [3:0] warn = '0, sev = '0;
  logic [1:0] below = '0, fault = '0;
  ecd_node_t id1 = '0, id2 = '0;
  logic [7:0] st, sf;
  logic ext, pc, hh, wa, sa, r1, r2, cl, unl, tq, em, l3, l4, net, cpu;
  ecd_note_s notes[$];
  ecd_note_s nt;
  int n_fail = 0, checked = 0, cycles = 0, seed = 21, hi;
  logic [31:0] w;
  logic [7:0] ob;

  always #12.5 i_clk = ~i_clk;

  ecd_field u_ecd_field (.i_clk(i_clk), .i_close(close), .o_pin(pin));
  ecd_top #(.DEB_CYC(DEB), .BOOT_CYC(BOOT), .FLASH_CYC(FLASH)) u_ecd_top (
    .i_clk(i_clk), .i_rstn(i_rstn), .i_contact(pin[7:0]), .i_port_sel_contact(pin[8]),
    .i_is_slave(slave), .i_warning_cause(warn), .i_severe_cause(sev),
    .i_warning_relay_polarity(pol_w), .i_severe_relay_polarity(pol_s),
    .i_input_f_role_select(role), .i_permissives_ok(perm), .i_load_at_unload_trip(trip),
    .i_run_mode(run), .i_below_failsafe(below), .i_net_node_id_chan_one(id1),
    .i_net_node_id_chan_two(id2), .i_chan_fault(fault), .i_reset_all_alarms(rst_all),
    .o_contact_status(st), .o_external_setpoint_chosen(ext), .o_pc_link_chosen(pc),
    .o_handheld_enable(hh), .o_warning_alarm(wa), .o_severe_alarm(sa), .o_relay_one(r1),
    .o_relay_two(r2), .o_clutch_relay(cl), .o_unload_request(unl),
    .o_torque_limit_active(tq), .o_emergency_declutch(em), .o_sensor_fail_led(sf),
    .o_led_three(l3), .o_led_four(l4), .o_net_functions_enable(net), .o_cpu_led(cpu));

  // ----------------------------------------
  // Checking
  // ----------------------------------------
  task automatic cmp_bit(string nm, logic e, logic s);
    checked++;
    if (s !== e) begin
      n_fail++;
      $display("ERROR %s expected %b seen %b", nm, e, s);
    end
  endtask
  task automatic cmp_vec(string nm, logic [7:0] e, logic [7:0] s);
    checked++;
    if (s !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  function automatic logic [7:0] obs(int sel);
    logic [14:0] b;
    b = {ext, pc, hh, wa, sa, r1, r2, cl, unl, tq, em, l3, l4, net, cpu};
    if (sel == 0) return st;
    if (sel == 1) return {6'h00, sf[1:0]};
    return {7'h00, b[sel - 2]};
  endfunction
  // Bit selectors into obs, counted from o_cpu_led upward
  localparam int CPU = 2, NET = 3, L4 = 4, L3 = 5, EM = 6, TQ = 7, UNL = 8, CL = 9;
  localparam int R2 = 10, R1 = 11, SA = 12, WA = 13, HH = 14, PC = 15, EXT = 16;
  task automatic add_note(string nm, int sel, logic [7:0] e);
    notes.push_back('{nm, sel, e});
  endtask
  // Settled one ns after the falling edge, when the driver has queued
  always @(negedge i_clk) begin
    #1;
    while (notes.size() > 0) begin
      nt = notes.pop_front();
      if (nt.sel < 2) cmp_vec(nt.nm, nt.exp, obs(nt.sel));
      else begin
        ob = obs(nt.sel);
        cmp_bit(nt.nm, nt.exp[0], ob[0]);
      end
    end
  end

  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Hang guard: whole run is well under this
  always @(posedge i_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      end_sim();
    end
  end
  task automatic cyc(int n);
    repeat (n) @(negedge i_clk);
  endtask

  // ----------------------------------------
  // Stimulus
  // ----------------------------------------
  initial begin
    cyc(2);
    i_rstn = 1'b1;
    add_note("status", 0, 8'h00);
    add_note("handheld", HH, 8'h01);
    cyc(BOOT - 8);
    add_note("cpu led early", CPU, 8'h00);
    cyc(10);
    add_note("cpu led", CPU, 8'h01);
    trip = 1'b1;
    for (int i = 0; i < 8; i++) begin
      close = 9'h001 << i;
      cyc(SETTLE);
      add_note("status one", 0, 8'h01 << i);
    end
    close = '0;
    cyc(SETTLE);
    add_note("status open", 0, 8'h00);
    close = 9'h002;
    cyc(2);
    close = '0;
    cyc(SETTLE);
    add_note("short pulse", 0, 8'h00);
    close = 9'h00C;
    cyc(SETTLE);
    add_note("ext setpoint", EXT, 8'h01);
    // Slave engine never takes the external setpoint
    slave = 1'b1;
    cyc(2);
    add_note("ext slave", EXT, 8'h00);
    slave = 1'b0;
    close = 9'h004;
    cyc(SETTLE);
    add_note("ext one open", EXT, 8'h00);
    close = 9'h100;
    cyc(SETTLE);
    add_note("pc link", PC, 8'h01);
    add_note("handheld off", HH, 8'h00);
    close = '0;
    cyc(SETTLE);
    add_note("handheld on", HH, 8'h01);
    // Alarm flags and both relay polarities
    for (int p = 0; p < 2; p++) begin
      pol_w = p[0];
      pol_s = p[0];
      w = $random(seed);
      warn = w[3:0] | 4'h1;
      sev = 4'h8;
      cyc(2);
      add_note("warn", WA, 8'h01);
      add_note("relay one", R1, {7'h00, !p[0]});
      add_note("severe", SA, 8'h01);
      add_note("relay two", R2, {7'h00, !p[0]});
      rst_all = 1'b1;
      cyc(2);
      add_note("warn cause held", WA, 8'h01);
      rst_all = 1'b0;
      warn = '0;
      sev = '0;
      cyc(2);
      rst_all = 1'b1;
      cyc(2);
      add_note("warn cleared", WA, 8'h00);
      add_note("relay one idle", R1, {7'h00, p[0]});
      add_note("severe cleared", SA, 8'h00);
      add_note("relay two idle", R2, {7'h00, p[0]});
      rst_all = 1'b0;
    end
    // Clutch: engaged feedback alone closes, then unloads with no demand
    trip = 1'b0;
    close = 9'h080;
    cyc(SETTLE);
    add_note("clutch by feedback", CL, 8'h01);
    close = '0;
    cyc(SETTLE);
    add_note("feedback unloading", UNL, 8'h01);
    trip = 1'b1;
    cyc(2);
    add_note("feedback released", CL, 8'h00);
    // Clutch: engage, unload ramp, emergency, torque role
    trip = 1'b0;
    perm = 1'b1;
    close = 9'h040;
    cyc(SETTLE);
    add_note("clutch closed", CL, 8'h01);
    close = '0;
    cyc(SETTLE);
    add_note("clutch unloading", CL, 8'h01);
    add_note("unload request", UNL, 8'h01);
    trip = 1'b1;
    cyc(2);
    add_note("clutch open", CL, 8'h00);
    add_note("unload done", UNL, 8'h00);
    trip = 1'b0;
    close = 9'h040;
    cyc(SETTLE);
    close = 9'h060;
    cyc(SETTLE);
    add_note("emergency open", CL, 8'h00);
    add_note("emergency flag", EM, 8'h01);
    role = 1'b1;
    cyc(3);
    add_note("torque role", TQ, 8'h01);
    add_note("no emergency", EM, 8'h00);
    add_note("clutch back", CL, 8'h01);
    close = '0;
    trip = 1'b1;
    role = 1'b0;
    cyc(SETTLE);
    // Speed sensor lamps, gated by run mode
    run = 1'b1;
    below = 2'b01;
    cyc(2);
    add_note("sensor lamp", 1, 8'h01);
    run = 1'b0;
    below = 2'b11;
    cyc(2);
    add_note("no lamp stopped", 1, 8'h01);
    below = 2'b00;
    rst_all = 1'b1;
    cyc(2);
    add_note("lamps cleared", 1, 8'h00);
    // Both channels faulted versus one
    fault = 2'b01;
    cyc(2);
    add_note("led four one", L4, 8'h00);
    add_note("net on", NET, 8'h01);
    fault = 2'b11;
    cyc(2);
    add_note("led four", L4, 8'h01);
    add_note("net off", NET, 8'h00);
    fault = 2'b00;
    // Node ids: valid pair stays dark, unset or equal ids flash
    w = $random(seed);
    id1 = {2'b00, w[5:0]} | 8'h01;
    id2 = id1 ^ 8'h40;
    cyc(2);
    for (int i = 0; i < 2 * FLASH + 2; i++) begin
      cyc(1);
      add_note("led three dark", L3, 8'h00);
    end
    for (int k = 0; k < 2; k++) begin
      if (k == 0) id1 = 8'h00;
      else id1 = id2;
      hi = 0;
      for (int i = 0; i < 2 * FLASH + 2; i++) begin
        cyc(1);
        hi += (l3 === 1'b1);
      end
      cmp_bit("led three flashes", 1'b1, hi > 0 && hi < 2 * FLASH + 2);
    end
    // Mid-run reset: lamps drop, start-up count runs again
    i_rstn = 1'b0;
    cyc(2);
    add_note("cpu led in reset", CPU, 8'h00);
    add_note("led three in reset", L3, 8'h00);
    add_note("handheld in reset", HH, 8'h01);
    i_rstn = 1'b1;
    cyc(BOOT + 2);
    add_note("cpu led again", CPU, 8'h01);
    cyc(2);
    end_sim();
  end
endmodule
